//--- lps_cmd_dec.v
// Purpose: Decodes the command strobes sampled at a clock edge.
// Assumes: Inputs are the pin levels present at the current edge.
// Notes:   Purely combinational; the caller acts on it at the edge.
`timescale 1ns/10ps
`include "lps_consts.vh"

module lps_cmd_dec (
    // Command strobes
    input  wire       cs_n,
    input  wire       ras_n,
    input  wire       cas_n,
    input  wire       we_n,
    // Decoded command
    output reg  [3:0] cmd
);

    always @* begin
        if (cs_n) begin
            cmd = `LPS_CMD_INHIBIT;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h7:    cmd = `LPS_CMD_NOP;
                3'h3:    cmd = `LPS_CMD_ACTIVE;
                3'h5:    cmd = `LPS_CMD_READ;
                3'h4:    cmd = `LPS_CMD_WRITE;
                3'h6:    cmd = `LPS_CMD_BST;
                3'h2:    cmd = `LPS_CMD_PRECHG;
                3'h1:    cmd = `LPS_CMD_REFRESH;
                3'h0:    cmd = `LPS_CMD_LOADMR;
                default: cmd = `LPS_CMD_NOP;
            endcase
        end
    end

endmodule

//--- lps_consts.vh
// Purpose: Shared constants for the low-power SDRAM pin interface.
// Assumes: Plain Verilog-2005, included by bare name.
// Notes:   Geometry, encodings, field positions, reset values, timing counts and buffer sizes only.
`ifndef LPS_CONSTS_VH
`define LPS_CONSTS_VH

// Array geometry: 4 banks x 8192 rows x 512 columns of 32 bits.
`define LPS_ADDR_W      24
`define LPS_WORDS       16777216
`define LPS_ROW_W       13
`define LPS_COL_W       9

// Decoded command codes.
`define LPS_CMD_INHIBIT 4'h0
`define LPS_CMD_NOP     4'h1
`define LPS_CMD_ACTIVE  4'h2
`define LPS_CMD_READ    4'h3
`define LPS_CMD_WRITE   4'h4
`define LPS_CMD_BST     4'h5
`define LPS_CMD_PRECHG  4'h6
`define LPS_CMD_REFRESH 4'h7
`define LPS_CMD_LOADMR  4'h8

// Burst states.
`define LPS_ST_IDLE     2'h0
`define LPS_ST_READ     2'h1
`define LPS_ST_WRITE    2'h2

// Mode register fields and reset values.
`define LPS_MR_BL_MSB   2
`define LPS_MR_BL_LSB   0
`define LPS_MR_BT_BIT   3
`define LPS_MR_CL_MSB   6
`define LPS_MR_CL_LSB   4
`define LPS_MR_WB_BIT   9
`define LPS_MR_RESET    14'h0030
`define LPS_EMR_RESET   14'h0000
`define LPS_BL_FULL     3'h7
`define LPS_AP_BIT      10

// Self refresh interval: 64 ms over 8192 rows, at a 25 ns clock.
`define LPS_REF_INT_NS  7812
`define LPS_CLK_NS      25
`define LPS_REF_CYCLES  (`LPS_REF_INT_NS / `LPS_CLK_NS)

// Read data buffer.
`define LPS_FIFO_DEPTH  4
`define LPS_DATA_W      32

`endif

//--- lps_ctrl_model.sv
// Purpose: Controller model that drives the SDRAM command and data pins.
// Assumes: Pins change just after a rising edge, held for one edge.
// Notes:   Released data lines are inverted on every release so stale data never matches.
`timescale 1ns/10ps

module lps_ctrl_model (
    // Clock
    input  wire logic        sys_clk,
    // Command pins
    output logic        cke,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [1:0]  ba,
    output logic [12:0] addr,
    // Data pins
    output logic [3:0]  dqm,
    output logic [31:0] dq_in
);
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
        {ba, addr, dqm, dq_in} = 51'h0;
    end

    task automatic nop_cyc();
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        dq_in <= ~dq_in;
    endtask

    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                         input logic k);
        @(posedge sys_clk);
        cke <= k;
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(posedge sys_clk);
        nop_cyc();
    endtask

    task automatic wr2(input logic [1:0] b, input logic [12:0] a, input logic [31:0] d0,
                       input logic [31:0] d1, input logic [3:0] m0, input logic [3:0] m1);
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h4;
        ba <= b;
        addr <= a;
        dq_in <= d0;
        dqm <= m0;
        @(posedge sys_clk);
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        dq_in <= d1;
        dqm <= m1;
        @(posedge sys_clk);
        dq_in <= ~d1;
        dqm <= 4'h0;
    endtask

    task automatic setm(input logic [3:0] m);
        dqm <= m;
    endtask
endmodule

//--- lps_fifo.v
// Purpose: Small first-in first-out buffer with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Full and empty are exact; no write when full, no read when empty.
`timescale 1ns/10ps

module lps_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             reset,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    reg  [WIDTH-1:0] store [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_reg;
    reg  [AW-1:0]    rd_ptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = store[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            store[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                   : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                   : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

//--- lps_sdram_core.v
// Purpose: Device-side logic of a four-bank 16M x 32 single-data-rate SDRAM.
// Assumes: All pins are synchronous to sys_clk; the data pin is split in three.
// Notes:   Read words queue in a small buffer until their CAS latency expires.
`timescale 1ns/10ps
`include "lps_consts.vh"

// Operation
// - Inputs captured only on rising edge.
// - Clock advances burst counter and outputs.
// - Clock enable low freezes or enters power-down.
// - Clock enable acts unclocked while asleep; here cke is sampled on the rising edge.
// - Inputs ignored during power-down and self refresh.
// - Chip select high masks every command.
// - Command from strobes sampled same edge.
// - Masked write bytes are not stored.
// - Masked read bytes float two clocks later.
// - Each mask bit governs one data byte.
// - Bank bits select bank or opcode.
// - Activate takes thirteen-bit row address.
// - Column from bits 8:0, bit 10 autoprecharge.
// - Precharge bit 10 closes all banks.
// - Load mode takes opcode from address.
// - Burst lengths one to eight, full page.
// - Four independent banks share one interface.
module lps_sdram_core (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        reset,
    // Command pins
    input  wire        cke,
    input  wire        cs_n,
    input  wire        ras_n,
    input  wire        cas_n,
    input  wire        we_n,
    input  wire [1:0]  ba,
    input  wire [12:0] addr,
    // Data pins
    input  wire [3:0]  dqm,
    input  wire [31:0] dq_in,
    output reg  [31:0] dq_out,
    output reg  [3:0]  dq_oe_n,
    // Status
    output reg  [3:0]  bank_open,
    output reg         pwr_down,
    output reg         self_refresh
);

    localparam integer REF_CYCLES_I = `LPS_REF_CYCLES;
    localparam [8:0]   REF_CYCLES   = REF_CYCLES_I[8:0];

    wire [3:0]  cmd;
    reg  [13:0] mode_reg;
    reg  [13:0] ext_mode_reg;
    reg  [12:0] row_reg [0:3];
    reg  [1:0]  st_reg;
    reg  [1:0]  bbank_reg;
    reg  [8:0]  start_reg;
    reg  [8:0]  cnt_reg;
    reg         ap_reg;
    reg  [2:0]  tok_reg;
    reg  [3:0]  dqm_d1_reg;
    reg  [3:0]  dqm_d2_reg;
    reg  [12:0] ref_row_reg;
    reg  [8:0]  ref_tmr_reg;
    reg  [8:0]  bl_mask;
    reg         tok_due;

    wire        asleep;
    wire        ce;
    wire        rd_cmd;
    wire        wr_cmd;
    wire        new_rw;
    wire        is_rd;
    wire        active;
    wire [1:0]  b_bank;
    wire [8:0]  b_start;
    wire [8:0]  b_cnt;
    wire        b_ap;
    wire [8:0]  b_mask;
    wire [8:0]  seq_off;
    wire [8:0]  off;
    wire [8:0]  col;
    wire [23:0] cur_addr;
    wire        beat_go;
    wire        last;
    wire        wr_beat;
    wire        rd_push;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire        fifo_out_ready;
    wire [31:0] fifo_out_data;
    wire [31:0] rd_word;
    wire        pop;
    wire        single_wr;
    wire [2:0]  bl_code;
    wire [2:0]  cl_code;

    lps_cmd_dec u_dec (
        .cs_n  (cs_n),
        .ras_n (ras_n),
        .cas_n (cas_n),
        .we_n  (we_n),
        .cmd   (cmd)
    );

    assign asleep = pwr_down | self_refresh;
    assign ce     = cke & ~asleep;

    assign bl_code   = mode_reg[`LPS_MR_BL_MSB:`LPS_MR_BL_LSB];
    assign cl_code   = mode_reg[`LPS_MR_CL_MSB:`LPS_MR_CL_LSB];
    assign single_wr = mode_reg[`LPS_MR_WB_BIT];

    always @* begin
        case (bl_code)
            3'h0:         bl_mask = 9'h000;
            3'h1:         bl_mask = 9'h001;
            3'h2:         bl_mask = 9'h003;
            3'h3:         bl_mask = 9'h007;
            `LPS_BL_FULL: bl_mask = 9'h1FF;
            default:      bl_mask = 9'h000;
        endcase
    end

    always @* begin
        case (cl_code)
            3'h1:    tok_due = tok_reg[0];
            3'h2:    tok_due = tok_reg[1];
            3'h3:    tok_due = tok_reg[2];
            default: tok_due = tok_reg[2];
        endcase
    end

    assign rd_cmd  = ce & (cmd == `LPS_CMD_READ) & bank_open[ba];
    assign wr_cmd  = ce & (cmd == `LPS_CMD_WRITE) & bank_open[ba];
    assign new_rw  = rd_cmd | wr_cmd;
    assign is_rd   = new_rw ? rd_cmd : (st_reg == `LPS_ST_READ);
    assign active  = new_rw | (ce & (st_reg != `LPS_ST_IDLE) & (cmd != `LPS_CMD_BST));

    assign b_bank  = new_rw ? ba : bbank_reg;
    assign b_start = new_rw ? addr[8:0] : start_reg;
    assign b_cnt   = new_rw ? 9'h000 : cnt_reg;
    assign b_ap    = new_rw ? addr[`LPS_AP_BIT] : ap_reg;
    assign b_mask  = (is_rd | ~single_wr) ? bl_mask : 9'h000;

    assign seq_off  = b_start + b_cnt;
    assign off      = mode_reg[`LPS_MR_BT_BIT] ? (b_start ^ b_cnt) : seq_off;
    assign col      = (b_start & ~b_mask) | (off & b_mask);
    assign cur_addr = {b_bank, row_reg[b_bank], col};

    assign beat_go = active & (~is_rd | fifo_in_ready);
    assign last    = beat_go & (b_cnt == b_mask) & (b_mask != 9'h1FF);
    assign wr_beat = beat_go & ~is_rd;
    assign rd_push = beat_go & is_rd;

    // Byte lanes of the array, one lane per mask bit.
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
            reg [7:0] lane_mem [0:`LPS_WORDS-1];
            always @(posedge sys_clk) begin
                if (wr_beat && !dqm[gb]) begin
                    lane_mem[cur_addr] <= dq_in[gb*8 +: 8];
                end
            end
            assign rd_word[gb*8 +: 8] = lane_mem[cur_addr];
        end
    endgenerate

    // Read words wait here until their latency has elapsed.
    lps_fifo #(
        .WIDTH (`LPS_DATA_W),
        .DEPTH (`LPS_FIFO_DEPTH)
    ) u_rd_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_valid  (rd_push),
        .in_ready  (fifo_in_ready),
        .in_data   (rd_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = ce & tok_due;
    assign pop            = fifo_out_ready & fifo_out_valid;

    // Power states: entry needs an idle burst engine, exit only needs cke.
    always @(posedge sys_clk) begin
        if (reset) begin
            pwr_down     <= 1'b0;
            self_refresh <= 1'b0;
        end else if (asleep) begin
            if (cke) begin
                pwr_down     <= 1'b0;
                self_refresh <= 1'b0;
            end
        end else if (!cke && st_reg == `LPS_ST_IDLE) begin
            if (cmd == `LPS_CMD_REFRESH && bank_open == 4'h0) begin
                self_refresh <= 1'b1;
            end else begin
                pwr_down <= 1'b1;
            end
        end
    end

    // Refresh row counter: steps per refresh command, or per interval in self refresh.
    always @(posedge sys_clk) begin
        if (reset) begin
            ref_row_reg <= 13'h0000;
            ref_tmr_reg <= 9'h000;
        end else if (self_refresh) begin
            if (ref_tmr_reg == REF_CYCLES - 9'h001) begin
                ref_tmr_reg <= 9'h000;
                ref_row_reg <= ref_row_reg + 13'h0001;
            end else begin
                ref_tmr_reg <= ref_tmr_reg + 9'h001;
            end
        end else begin
            ref_tmr_reg <= 9'h000;
            if (ce && cmd == `LPS_CMD_REFRESH && bank_open == 4'h0) begin
                ref_row_reg <= ref_row_reg + 13'h0001;
            end
        end
    end

    // Bank, mode and burst control, all frozen while the clock is gated.
    always @(posedge sys_clk) begin
        if (reset) begin
            mode_reg     <= `LPS_MR_RESET;
            ext_mode_reg <= `LPS_EMR_RESET;
            bank_open    <= 4'h0;
            st_reg       <= `LPS_ST_IDLE;
            bbank_reg    <= 2'h0;
            start_reg    <= 9'h000;
            cnt_reg      <= 9'h000;
            ap_reg       <= 1'b0;
            row_reg[0]   <= 13'h0000;
            row_reg[1]   <= 13'h0000;
            row_reg[2]   <= 13'h0000;
            row_reg[3]   <= 13'h0000;
        end else if (ce) begin
            case (cmd)
                `LPS_CMD_ACTIVE: begin
                    if (!bank_open[ba]) begin
                        bank_open[ba] <= 1'b1;
                        row_reg[ba]   <= addr;
                    end
                end
                `LPS_CMD_PRECHG: begin
                    if (addr[`LPS_AP_BIT]) begin
                        bank_open <= 4'h0;
                    end else begin
                        bank_open[ba] <= 1'b0;
                    end
                    if (addr[`LPS_AP_BIT] || ba == bbank_reg) begin
                        st_reg <= `LPS_ST_IDLE;
                    end
                end
                `LPS_CMD_LOADMR: begin
                    if (bank_open == 4'h0 && st_reg == `LPS_ST_IDLE) begin
                        // Address bit 12 has no mode bit; the bank bits fill 13:12.
                        if (ba[1]) begin
                            ext_mode_reg <= {ba, addr[11:0]};
                        end else begin
                            mode_reg <= {ba, addr[11:0]};
                        end
                    end
                end
                `LPS_CMD_BST: begin
                    st_reg <= `LPS_ST_IDLE;
                end
                default: begin
                end
            endcase
            if (new_rw) begin
                bbank_reg <= ba;
                start_reg <= addr[8:0];
                ap_reg    <= addr[`LPS_AP_BIT];
                st_reg    <= rd_cmd ? `LPS_ST_READ : `LPS_ST_WRITE;
                cnt_reg   <= 9'h000;
            end
            if (beat_go) begin
                if (last) begin
                    st_reg <= `LPS_ST_IDLE;
                    if (b_ap) begin
                        bank_open[b_bank] <= 1'b0;
                    end
                end else begin
                    cnt_reg <= b_cnt + 9'h001;
                end
            end
        end
    end

    // Output registers, latency tokens and the mask delay line.
    always @(posedge sys_clk) begin
        if (reset) begin
            tok_reg    <= 3'h0;
            dqm_d1_reg <= 4'hF;
            dqm_d2_reg <= 4'hF;
            dq_out     <= 32'h00000000;
            dq_oe_n    <= 4'hF;
        end else if (ce) begin
            tok_reg    <= {tok_reg[1:0], rd_push};
            dqm_d1_reg <= dqm;
            dqm_d2_reg <= dqm_d1_reg;
            if (pop) begin
                dq_out <= fifo_out_data;
            end
            dq_oe_n <= {4{~pop}} | dqm_d2_reg;
        end else if (asleep) begin
            dq_oe_n <= 4'hF;
        end else if (!cke && st_reg == `LPS_ST_IDLE) begin
            dq_oe_n <= 4'hF;
        end
    end

endmodule

//--- lps_sdram_core_test.sv
// Purpose: Self-checking bench for the SDRAM pin interface.
// Assumes: Controller model drives every input except clock and reset.
// Notes:   Mode is BL2 CL2 unless a scenario reloads it.
`timescale 1ns/10ps

module lps_sdram_core_test;
    localparam logic [3:0] c_act = 4'h3, c_rd = 4'h5, c_pre = 4'h2, c_ref = 4'h1;
    localparam logic [3:0] c_lmr = 4'h0, c_nop = 4'h7;
    logic        sys_clk = 1'b0;
    logic        reset;
    logic        cke, cs_n, ras_n, cas_n, we_n, pwr_down, self_refresh;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [3:0]  dqm, dq_oe_n, bank_open;
    logic [31:0] dq_in, dq_out;
    integer      mismatches = 0;
    integer      checks_done = 0;

    always #12.5 sys_clk = ~sys_clk;

    lps_ctrl_model u_lps_ctrl_model (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm),
        .dq_in(dq_in));
    lps_sdram_core u_lps_sdram_core (.sys_clk(sys_clk), .reset(reset), .cke(cke),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
        .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .bank_open(bank_open), .pwr_down(pwr_down), .self_refresh(self_refresh));

    task automatic cmp4(input logic [3:0] got, input logic [3:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic t_init();
        #1;
        cmp4(dq_oe_n, 4'hF, "reset oe");
        cmp4({2'h0, self_refresh, pwr_down} | bank_open, 4'h0, "reset status");
        repeat (8000) @(posedge sys_clk);
        u_lps_ctrl_model.issue(c_pre, 2'h0, 13'h0400, 1'b1);
        u_lps_ctrl_model.issue(c_ref, 2'h0, 13'h0000, 1'b1);
        u_lps_ctrl_model.issue(c_ref, 2'h0, 13'h0000, 1'b1);
        u_lps_ctrl_model.issue(c_lmr, 2'h0, 13'h0021, 1'b1);
    endtask

    task automatic t_banks();
        u_lps_ctrl_model.issue(c_act, 2'h2, 13'h1ABC, 1'b1);
        #1 cmp4(bank_open, 4'h4, "act bank2");
        u_lps_ctrl_model.issue(4'hB, 2'h1, 13'h0001, 1'b1);
        #1 cmp4(bank_open, 4'h4, "deselected act");
        u_lps_ctrl_model.issue(c_pre, 2'h2, 13'h0000, 1'b1);
        #1 cmp4(bank_open, 4'h0, "pre bank2");
        u_lps_ctrl_model.issue(c_act, 2'h0, 13'h0005, 1'b1);
        u_lps_ctrl_model.issue(c_act, 2'h3, 13'h1FFF, 1'b1);
        #1 cmp4(bank_open, 4'h9, "two banks");
        u_lps_ctrl_model.issue(c_pre, 2'h0, 13'h0400, 1'b1);
        #1 cmp4(bank_open, 4'h0, "pre all");
    endtask

    task automatic t_wr_rd();
        u_lps_ctrl_model.issue(c_act, 2'h0, 13'h0005, 1'b1);
        u_lps_ctrl_model.wr2(2'h0, 13'h0004, 32'h11223344, 32'h55667788, 4'h0, 4'h0);
        u_lps_ctrl_model.wr2(2'h0, 13'h0005, 32'hA1B2C3D4, 32'hEEEEEEEE, 4'h2, 4'hF);
        u_lps_ctrl_model.issue(c_rd, 2'h0, 13'h0004, 1'b1);
        u_lps_ctrl_model.setm(4'h8);
        @(posedge sys_clk);
        u_lps_ctrl_model.setm(4'h0);
        step();
        cmp32(dq_out, 32'h11223344, "word col4");
        cmp4(dq_oe_n, 4'h0, "word col4 oe");
        step();
        cmp32({8'h0, dq_out[23:0]}, 32'h00B277D4, "word col5");
        cmp4(dq_oe_n, 4'h8, "masked byte3");
        step();
        cmp4(dq_oe_n, 4'hF, "after burst");
    endtask

    task automatic t_burst1();
        u_lps_ctrl_model.issue(c_pre, 2'h0, 13'h0400, 1'b1);
        u_lps_ctrl_model.issue(c_lmr, 2'h0, 13'h0020, 1'b1);
        u_lps_ctrl_model.issue(c_act, 2'h1, 13'h0007, 1'b1);
        u_lps_ctrl_model.wr2(2'h1, 13'h0002, 32'h0BADF00D, 32'h12345678, 4'h0, 4'h0);
        u_lps_ctrl_model.issue(c_rd, 2'h1, 13'h0002, 1'b1);
        repeat (2) step();
        cmp32(dq_out, 32'h0BADF00D, "single word");
        step();
        cmp4(dq_oe_n, 4'hF, "one beat only");
    endtask

    task automatic t_modes();
        u_lps_ctrl_model.issue(c_pre, 2'h0, 13'h0400, 1'b1);
        u_lps_ctrl_model.issue(c_lmr, 2'h0, 13'h0039, 1'b1);
        u_lps_ctrl_model.issue(c_act, 2'h0, 13'h0005, 1'b1);
        u_lps_ctrl_model.issue(c_rd, 2'h0, 13'h0405, 1'b1);
        step();
        cmp4(bank_open, 4'h0, "autoprecharge");
        repeat (2) step();
        cmp32(dq_out, 32'hA1B277D4, "interleaved first");
        cmp4(dq_oe_n, 4'h0, "latency three oe");
        step();
        cmp32(dq_out, 32'h11223344, "interleaved second");
    endtask

    task automatic t_power();
        u_lps_ctrl_model.issue(c_pre, 2'h0, 13'h0400, 1'b1);
        u_lps_ctrl_model.issue(c_nop, 2'h0, 13'h0000, 1'b0);
        #1 cmp4({2'h0, self_refresh, pwr_down}, 4'h1, "power-down");
        u_lps_ctrl_model.issue(c_act, 2'h1, 13'h0003, 1'b0);
        #1 cmp4(bank_open, 4'h0, "act while asleep");
        u_lps_ctrl_model.issue(c_nop, 2'h0, 13'h0000, 1'b1);
        #1 cmp4({2'h0, self_refresh, pwr_down}, 4'h0, "wake");
        u_lps_ctrl_model.issue(c_ref, 2'h0, 13'h0000, 1'b0);
        #1 cmp4({2'h0, self_refresh, pwr_down}, 4'h2, "self refresh");
        repeat (400) @(posedge sys_clk);
        #1 cmp4({2'h0, self_refresh, pwr_down}, 4'h2, "stays asleep");
        u_lps_ctrl_model.issue(c_nop, 2'h0, 13'h0000, 1'b1);
        #1 cmp4({2'h0, self_refresh, pwr_down}, 4'h0, "sref exit");
        u_lps_ctrl_model.issue(c_act, 2'h1, 13'h0003, 1'b1);
        #1 cmp4(bank_open, 4'h2, "act after wake");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        t_init();
        t_banks();
        t_wr_rd();
        t_burst1();
        t_modes();
        t_power();
        results();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        results();
    end
endmodule

bind lps_sdram_core lps_sdram_props u_lps_sdram_props (.sys_clk(sys_clk), .reset(reset),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .bank_open(bank_open), .pwr_down(pwr_down), .self_refresh(self_refresh));

//--- lps_sdram_props.sv
// Purpose: Port checker for the SDRAM pin interface.
// Assumes: Sees only the ports of lps_sdram_core.
// Notes:   Bound from the testbench file.
`timescale 1ns/10ps

module lps_sdram_props (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // Command pins
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  ba,
    input wire logic [12:0] addr,
    // Data pins
    input wire logic [3:0]  dqm,
    input wire logic [31:0] dq_in,
    input wire logic [31:0] dq_out,
    input wire logic [3:0]  dq_oe_n,
    // Status
    input wire logic [3:0]  bank_open,
    input wire logic        pwr_down,
    input wire logic        self_refresh
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire       sleep = pwr_down || self_refresh;
    wire       taken = cke && !sleep && !cs_n;
    wire [2:0] rcw   = {ras_n, cas_n, we_n};

    a_cs_ignore: assert property (cs_n |=> (bank_open & ~$past(bank_open)) == 4'h0)
        else $error("bank opened while deselected");
    a_act_opens: assert property (taken && rcw == 3'h3 |=> bank_open[$past(ba)])
        else $error("activate left bank closed");
    a_pre_all: assert property (taken && rcw == 3'h2 && addr[10] |=> bank_open == 4'h0)
        else $error("precharge all left a bank open");
    a_pre_one: assert property (taken && rcw == 3'h2 && !addr[10] |=> !bank_open[$past(ba)])
        else $error("precharge left named bank open");
    a_mask_float: assert property ((dq_oe_n | ~$past(dqm, 3)) == 4'hF)
        else $error("masked byte driven");
    a_sleep_float: assert property (sleep |-> dq_oe_n == 4'hF)
        else $error("data driven while asleep");
    a_wake_clear: assert property (sleep && cke |=> !pwr_down && !self_refresh)
        else $error("clock enable did not wake");
    a_sref_entry: assert property (!cke && !sleep && !cs_n && rcw == 3'h1 && bank_open == 4'h0
        |=> self_refresh)
        else $error("self refresh not entered");

    cover property (taken && rcw == 3'h5);
    cover property ($rose(self_refresh));
    cover property ($rose(pwr_down));
endmodule
